// ==== sim/ivm_host_model.sv ====
// Host side of the management link: framing, link clock and read capture
`timescale 1ns/1ps
module ivm_host_model
  import ivm_pkg::*;
(
  output logic      link_clk,
  output logic      link_frame_n,
  output logic      link_din,
  input  wire logic link_dout,
  input  wire logic link_dout_oe
);
  initial begin
    link_clk     = 1'b0;
    link_frame_n = 1'b1;
    link_din     = 1'b1;
  end

  // ****************************************
  // One 25-bit frame, MSB first
  // ****************************************
  // Clock stands still between frames
  task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [15:0] data, output logic [15:0] rdata);
    ivm_req_t    req;
    logic [24:0] bits;
    req = '{rd, cmd, data};
    bits = req;
    rdata = 16'h0000;
    #3.3;
    link_frame_n = 1'b0;
    for (int i = 24; i >= 0; i--) begin
      link_din = bits[i];
      #7.5 link_clk = 1'b1;
      #7.5 link_clk = 1'b0;
      if (i >= 1 && i <= 16) rdata[i-1] = link_dout;
    end
    // Idle data line shows the inverse of the last bit
    link_din = ~link_din;
    #7.5 link_frame_n = 1'b1;
    #60;
  endtask : xfer
endmodule : ivm_host_model

// ==== sim/ivm_input_voltage_limit_monitor_checker.sv ====
// Port-level assertions of the input voltage limit monitor
`timescale 1ns/1ps
module ivm_input_voltage_limit_monitor_checker
  import ivm_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        link_clk,
  input wire logic        link_frame_n,
  input wire logic        link_dout_oe,
  input wire logic        vin_sample_valid,
  input wire logic        enable_pin,
  input wire logic        bias_ok_pin,
  input wire logic        operation_on,
  input wire logic        other_fault,
  input wire logic        power_stage_en,
  input wire logic        alert_line_n_out,
  input wire logic        alert_line_n_oe
);
  logic [3:0] since_valid, since_off, since_frame;
  wire logic  off_cond = !enable_pin || !bias_ok_pin || !operation_on || other_fault;

  // Cycles since each cause; saturates so stale causes never look fresh
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_valid <= 4'hf;
      since_off   <= 4'hf;
      since_frame <= 4'hf;
    end else begin
      since_valid <= vin_sample_valid ? 4'h0 : since_valid + 4'(since_valid != 4'hf);
      since_off   <= off_cond ? 4'h0 : since_off + 4'(since_off != 4'hf);
      since_frame <= !link_frame_n ? 4'h0 : since_frame + 4'(since_frame != 4'hf);
    end
  end

  chk_alert_pull: assert property (@(posedge clk) disable iff (sys_rst)
    alert_line_n_oe |-> !alert_line_n_out) else $error("alert line driven high");
  chk_alert_cause: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(alert_line_n_oe) |-> since_valid <= 4'h6) else $error("alert raised without a sample");
  chk_alert_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(alert_line_n_oe) |-> since_frame <= 4'h8) else $error("alert dropped without a command");
  chk_off_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    off_cond [*6] |-> !power_stage_en) else $error("output on while commanded off");
  chk_on_cause: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(power_stage_en) |-> $past(operation_on) && !$past(other_fault)) else $error("output on while blocked");
  chk_off_cause: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(power_stage_en) |-> since_valid <= 4'h6 || since_off <= 4'h8 || !$past(power_stage_en, 2))
    else $error("output dropped without cause");
  chk_oe_frame: assert property (@(posedge link_clk) disable iff (sys_rst)
    link_dout_oe |-> !link_frame_n) else $error("data driven outside a frame");
  chk_oe_len: assert property (@(posedge link_clk) disable iff (sys_rst)
    $rose(link_dout_oe) |-> link_dout_oe [*8] ##8 link_dout_oe ##1 !link_dout_oe)
    else $error("data phase not sixteen bits");
endmodule : ivm_input_voltage_limit_monitor_checker

bind ivm_input_voltage_limit_monitor ivm_input_voltage_limit_monitor_checker i_chk (.clk, .sys_rst, .link_clk,
  .link_frame_n, .link_dout_oe, .vin_sample_valid, .enable_pin, .bias_ok_pin, .operation_on, .other_fault,
  .power_stage_en, .alert_line_n_out, .alert_line_n_oe);

// ==== sim/ivm_input_voltage_limit_monitor_test.sv ====
// Self-checking bench of the input voltage limit monitor
`timescale 1ns/1ps
module ivm_input_voltage_limit_monitor_test
  import ivm_pkg::*;
;
  localparam int unsigned UNIT = 20;
  logic        clk, sys_rst, link_clk, link_frame_n, link_din, link_dout, link_dout_oe;
  logic [15:0] vin_sample;
  logic        vin_sample_valid, enable_pin, bias_ok_pin, operation_on, other_fault;
  logic        power_stage_en, alert_line_n_out, alert_line_n_oe;
  logic [7:0]  resp_tab [2] = '{8'hb9, 8'hbf};
  int          err_count, total_checks, cycles, n, n2, n3;

  ivm_input_voltage_limit_monitor #(.RETRY_UNIT_CYCLES(UNIT)) i_dut (.clk, .sys_rst, .link_clk, .link_frame_n,
    .link_din, .link_dout, .link_dout_oe, .vin_sample, .vin_sample_valid, .enable_pin, .bias_ok_pin,
    .operation_on, .other_fault, .power_stage_en, .alert_line_n_out, .alert_line_n_oe);
  ivm_host_model i_host (.link_clk, .link_frame_n, .link_din, .link_dout, .link_dout_oe);

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      summarize();
    end
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] unused;
    i_host.xfer(1'b0, c, d, unused);
  endtask : wr
  // Answer comes in the next frame; command 00 writes nothing
  task automatic rchk(input string w, input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    i_host.xfer(1'b1, c, 16'h0000, d);
    i_host.xfer(1'b0, 8'h00, 16'h0000, d);
    check(w, d, e);
  endtask : rchk
  task automatic sample(input logic [15:0] v);
    @(negedge clk);
    vin_sample = v;
    vin_sample_valid = 1'b1;
    @(negedge clk);
    vin_sample_valid = 1'b0;
    repeat (6) @(negedge clk);
  endtask : sample
  task automatic wait_pwr(input logic e, output int k);
    k = 0;
    while (power_stage_en !== e && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_pwr
  task automatic uv_trip(input logic [7:0] r);
    wr(CMD_UV_RESP, {8'h00, r});
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    sample(16'hcb40);
    wait_pwr(1'b0, n);
  endtask : uv_trip
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    vin_sample = 16'hd300;
    vin_sample_valid = 1'b0;
    enable_pin = 1'b1;
    bias_ok_pin = 1'b1;
    operation_on = 1'b1;
    other_fault = 1'b0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rchk("ov_warn", CMD_OV_WARN, 16'hd3a0);
    rchk("uv_warn", CMD_UV_WARN, 16'hcba6);
    rchk("uv_fault", CMD_UV_FAULT, 16'hcb73);
    rchk("uv_resp", CMD_UV_RESP, 16'h00bf);
    wr(CMD_OV_WARN, 16'hd2c0);
    rchk("ov_rw", CMD_OV_WARN, 16'hd2c0);
    sample(16'hd300);
    rchk("st_in_ov", CMD_STATUS_INPUT, 16'h0040);
    rchk("st_word", CMD_STATUS_WORD, 16'h2001);
    check("alert_ov", alert_line_n_oe, 1'b1);
    wr(CMD_OV_WARN, 16'hd3a0);
    sample(16'hd300);
    rchk("st_kept", CMD_STATUS_INPUT, 16'h0040);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    rchk("st_clr", CMD_STATUS_INPUT, 16'h0000);
    check("alert_clr", alert_line_n_oe, 1'b0);
    sample(16'hcb80);
    rchk("st_uvw", CMD_STATUS_INPUT, 16'h0020);
    rchk("st_word_uv", CMD_STATUS_WORD, 16'h2001);
    check("uvw_on", power_stage_en, 1'b1);
    sample(16'hd300);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    // Retry spacing, short and longest delay
    foreach (resp_tab[j]) begin
      wr(CMD_UV_RESP, {8'h00, resp_tab[j]});
      sample(16'hcb40);
      wait_pwr(1'b1, n);
      wait_pwr(1'b0, n2);
      wait_pwr(1'b1, n3);
      check("retry_gap", 16'(n2 + n3), 16'((resp_tab[j][2:0] + 1) * UNIT));
    end
    rchk("st_uvf", CMD_STATUS_INPUT, 16'h0030);
    sample(16'hcb80);
    wait_pwr(1'b1, n);
    wait_pwr(1'b0, n2);
    check("uv_hyst", 16'(n2), 16'h0001);
    sample(16'hd300);
    repeat (200) @(negedge clk);
    check("uv_release", power_stage_en, 1'b1);
    uv_trip(8'hc0);
    sample(16'hcb80);
    repeat (200) @(negedge clk);
    check("hold_off", power_stage_en, 1'b0);
    sample(16'hd300);
    wait_pwr(1'b1, n);
    check("hold_on", power_stage_en, 1'b1);
    uv_trip(8'h80);
    sample(16'hd300);
    repeat (200) @(negedge clk);
    check("latch_off", power_stage_en, 1'b0);
    operation_on = 1'b0;
    repeat (8) @(negedge clk);
    operation_on = 1'b1;
    wait_pwr(1'b1, n);
    check("restart", power_stage_en, 1'b1);
    uv_trip(8'hbf);
    enable_pin = 1'b0;
    sample(16'hd300);
    repeat (200) @(negedge clk);
    check("en_off", power_stage_en, 1'b0);
    enable_pin = 1'b1;
    wait_pwr(1'b1, n);
    check("en_on", power_stage_en, 1'b1);
    wr(CMD_UV_RESP, 16'h003f);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    sample(16'hcb40);
    check("flag_only", power_stage_en, 1'b1);
    rchk("st_flag", CMD_STATUS_INPUT, 16'h0030);
    sample(16'hd300);
    wr(CMD_UV_RESP, 16'h00bf);
    @(negedge clk);
    other_fault = 1'b1;
    repeat (10) @(negedge clk);
    check("other_off", power_stage_en, 1'b0);
    other_fault = 1'b0;
    summarize();
  end
endmodule : ivm_input_voltage_limit_monitor_test

// ==== src/ivm_input_voltage_limit_monitor.sv ====
// Input voltage supervision: limits, status, alert and under-voltage response
// Contract
// RULE_01: Input above over-voltage warning sets summary, input, warning bits; alert host.
// RULE_02: Input below under-voltage warning sets summary, input, warning bits; alert host.
// RULE_03: Under-voltage fault clears only when input rises above warning threshold.
// RULE_04: Separate fault threshold; input below it declares under-voltage fault.
// RULE_05: Thresholds are linear-11 words: signed exponent high, signed mantissa low.
// RULE_06: All four settings exist once, shared by the whole device.
// RULE_07: Over-voltage warning threshold resets to d3a0.
// RULE_08: Under-voltage warning threshold resets to cba6.
// RULE_09: Under-voltage fault threshold resets to cb73.
// RULE_10: Fault response byte resets to bf: continuous retries, longest delay.
// RULE_11: Under-voltage fault pulls alert low and sets its status fault bit.
// RULE_12: Fault bits stay set until clear-faults command; nothing else clears them.
// RULE_13: Response mode 10 disables output then retries per bits 5:3.
// RULE_14: Response mode 11 holds output off until input above warning limit.
// RULE_15: Retry setting 000 never retries; output off until restart.
// RULE_16: Retry setting 111 retries until commanded off, bias lost or other fault.
// RULE_17: Retry delay is delay field plus one times 35 ms.
// RULE_18: Retry interval runs from start of one attempt to start of next.
// RULE_19: Host should keep the response at its default setting.
// RULE_20: Warnings also pull alert low until status is cleared.
// RULE_21: Mode 11 resumes on the input under-voltage warning limit.
`timescale 1ns/1ps
module ivm_input_voltage_limit_monitor
  import ivm_pkg::*;
#(
  parameter int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_CYC_DEF
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        link_clk,
  input  wire logic        link_frame_n,
  input  wire logic        link_din,
  output logic             link_dout,
  output logic             link_dout_oe,
  input  wire logic [15:0] vin_sample,
  input  wire logic        vin_sample_valid,
  input  wire logic        enable_pin,
  input  wire logic        bias_ok_pin,
  input  wire logic        operation_on,
  input  wire logic        other_fault,
  output logic             power_stage_en,
  output logic             alert_line_n_out,
  output logic             alert_line_n_oe
);

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (RETRY_UNIT_CYCLES == 0 || RETRY_UNIT_CYCLES > 32'd8_000_000) begin : g_bad_unit
      $error("RETRY_UNIT_CYCLES out of range");
    end
  endgenerate

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] ov_warn_reg;
  logic [15:0] uv_warn_reg;
  logic [15:0] uv_fault_reg;
  logic [7:0]  uv_resp_reg;

  logic        ov_warn_flag_reg;
  logic        uv_warn_flag_reg;
  logic        uv_fault_flag_reg;
  logic        uv_active_reg;

  ivm_state_t  state_reg;
  ivm_state_t  state_next;
  logic [25:0] retry_cnt_reg;
  logic [25:0] retry_target;

  logic        en_s1_reg;
  logic        en_s2_reg;
  logic        bias_s1_reg;
  logic        bias_s2_reg;
  logic        on_cmd;

  logic        req_s1_reg;
  logic        req_s2_reg;
  logic        req_s3_reg;
  logic        req_evt;
  ivm_req_t    req_hold;
  logic        req_tgl;
  logic        wr_evt;
  logic        rd_evt;
  logic        clear_evt;
  logic [15:0] rd_data_reg;
  logic        rd_ack_tgl_reg;

  logic        above_ov_warn;
  logic        below_uv_warn;
  logic        above_uv_warn;
  logic        below_uv_fault;
  logic        fault_seen;
  logic [7:0]  status_input;
  logic [15:0] status_word;

  logic [1:0]  resp_mode;
  logic [2:0]  retry_set;
  logic [2:0]  retry_delay;

  assign resp_mode   = uv_resp_reg[RESP_MODE_LSB +: 2];
  assign retry_set   = uv_resp_reg[RETRY_LSB +: 3];
  assign retry_delay = uv_resp_reg[DELAY_LSB +: 3];

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [25:0] delay_cycles(input logic [2:0] d);
    logic [31:0] prod;
    prod = (32'(d) + 32'd1) * RETRY_UNIT_CYCLES;
    return prod[25:0];
  endfunction : delay_cycles

  function automatic logic [15:0] read_mux(input logic [7:0] cmd,
                                           input logic [15:0] sw,
                                           input logic [7:0]  si);
    logic [15:0] r;
    r = 16'h0000;
    unique case (cmd)
      CMD_OV_WARN:      r = ov_warn_reg;
      CMD_UV_WARN:      r = uv_warn_reg;
      CMD_UV_FAULT:     r = uv_fault_reg;
      CMD_UV_RESP:      r = {8'h00, uv_resp_reg};
      CMD_STATUS_WORD:  r = sw;
      CMD_STATUS_INPUT: r = {8'h00, si};
      default:          r = 16'h0000;
    endcase
    return r;
  endfunction : read_mux

  // ****************************************
  // Link port and crossing
  // ****************************************
  ivm_link_port u_link (
    .link_clk     (link_clk),
    .sys_rst      (sys_rst),
    .link_frame_n (link_frame_n),
    .link_din     (link_din),
    .rd_data      (rd_data_reg),
    .rd_ack_tgl   (rd_ack_tgl_reg),
    .link_dout    (link_dout),
    .link_dout_oe (link_dout_oe),
    .req_hold     (req_hold),
    .req_tgl      (req_tgl)
  );

  // Toggle synchroniser; the hold word is stable by the time the edge is seen
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  assign req_evt   = req_s2_reg ^ req_s3_reg;
  assign wr_evt    = req_evt && !req_hold.rd;
  assign rd_evt    = req_evt && req_hold.rd;
  assign clear_evt = wr_evt && req_hold.cmd == CMD_CLEAR_FAULTS;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg    <= 16'h0000;
      rd_ack_tgl_reg <= 1'b0;
    end else if (rd_evt) begin
      rd_data_reg    <= read_mux(req_hold.cmd, status_word, status_input);
      rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
    end
  end

  // ****************************************
  // Threshold and response settings
  // ****************************************
  // One global copy; there is no paging of these settings [RULE_06]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_warn_reg  <= OV_WARN_RST;  // [RULE_07]
      uv_warn_reg  <= UV_WARN_RST;  // [RULE_08]
      uv_fault_reg <= UV_FAULT_RST; // [RULE_09]
      uv_resp_reg  <= UV_RESP_RST;  // [RULE_10]
    end else if (wr_evt) begin
      unique case (req_hold.cmd)
        CMD_OV_WARN:  ov_warn_reg  <= req_hold.data;
        CMD_UV_WARN:  uv_warn_reg  <= req_hold.data;
        CMD_UV_FAULT: uv_fault_reg <= req_hold.data;
        CMD_UV_RESP:  uv_resp_reg  <= req_hold.data[7:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Comparison of the measured input
  // ****************************************
  // Both sides decoded as mantissa times two to the exponent [RULE_05]
  ivm_lin11_cmp u_cmp_ov (
    .a      (vin_sample),
    .b      (ov_warn_reg),
    .a_gt_b (above_ov_warn),
    .a_lt_b ()
  );

  ivm_lin11_cmp u_cmp_uvw (
    .a      (vin_sample),
    .b      (uv_warn_reg),
    .a_gt_b (above_uv_warn),
    .a_lt_b (below_uv_warn)
  );

  ivm_lin11_cmp u_cmp_uvf (
    .a      (vin_sample),
    .b      (uv_fault_reg),
    .a_gt_b (),
    .a_lt_b (below_uv_fault)
  );

  assign fault_seen = vin_sample_valid && below_uv_fault; // [RULE_04]

  // Fault condition with hysteresis: set below fault, released above warning
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      uv_active_reg <= 1'b0;
    end else if (fault_seen) begin
      uv_active_reg <= 1'b1;
    end else if (vin_sample_valid && above_uv_warn) begin
      uv_active_reg <= 1'b0; // [RULE_03]
    end
  end

  // ****************************************
  // Sticky status
  // ****************************************
  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_warn_flag_reg <= 1'b0;
    end else if (vin_sample_valid && above_ov_warn) begin
      ov_warn_flag_reg <= 1'b1; // [RULE_01]
    end else if (clear_evt) begin
      ov_warn_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      uv_warn_flag_reg <= 1'b0;
    end else if (vin_sample_valid && below_uv_warn) begin
      uv_warn_flag_reg <= 1'b1; // [RULE_02]
    end else if (clear_evt) begin
      uv_warn_flag_reg <= 1'b0;
    end
  end

  // Only the clear command releases the fault bit, not the input recovering
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      uv_fault_flag_reg <= 1'b0;
    end else if (fault_seen) begin
      uv_fault_flag_reg <= 1'b1; // [RULE_11]
    end else if (clear_evt) begin
      uv_fault_flag_reg <= 1'b0; // [RULE_12]
    end
  end

  always_comb begin
    status_input               = 8'h00;
    status_input[SIN_OV_WARN]  = ov_warn_flag_reg;
    status_input[SIN_UV_WARN]  = uv_warn_flag_reg;
    status_input[SIN_UV_FAULT] = uv_fault_flag_reg;
    status_word                = 16'h0000;
    status_word[SW_INPUT]      = |status_input; // [RULE_01] [RULE_02]
    status_word[SW_NONE]       = |status_input;
  end

  // Open-drain alert: driven low while any input status bit is set
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_line_n_out <= 1'b0;
      alert_line_n_oe  <= 1'b0;
    end else begin
      alert_line_n_out <= 1'b0;
      alert_line_n_oe  <= |status_input; // [RULE_11] [RULE_20]
    end
  end

  // ****************************************
  // Enable inputs
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_s1_reg   <= 1'b0;
      en_s2_reg   <= 1'b0;
      bias_s1_reg <= 1'b0;
      bias_s2_reg <= 1'b0;
    end else begin
      en_s1_reg   <= enable_pin;
      en_s2_reg   <= en_s1_reg;
      bias_s1_reg <= bias_ok_pin;
      bias_s2_reg <= bias_s1_reg;
    end
  end

  assign on_cmd = en_s2_reg && bias_s2_reg && operation_on && !other_fault; // [RULE_16]

  // ****************************************
  // Retry timer
  // ****************************************
  // Counts from each attempt start, that cycle included, so the delay is start to start
  assign retry_target = delay_cycles(retry_delay); // [RULE_17]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      retry_cnt_reg <= 26'h0000000;
    end else if (state_next == ST_RUN && state_reg != ST_RUN) begin
      retry_cnt_reg <= 26'h0000001; // [RULE_18]
    end else if (retry_cnt_reg != 26'h3ffffff) begin
      retry_cnt_reg <= retry_cnt_reg + 26'h0000001;
    end
  end

  // ****************************************
  // Output control
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF: begin
        if (on_cmd) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!on_cmd) begin
          state_next = ST_OFF;
        end else if (uv_active_reg && resp_mode == MODE_HOLD) begin
          state_next = ST_HOLD; // [RULE_14]
        end else if (uv_active_reg && resp_mode == MODE_RETRY) begin
          // Unused retry codes behave as no retry
          state_next = (retry_set == RETRY_EVER) ? ST_RETRY : ST_LATCH; // [RULE_13] [RULE_15]
        end
      end
      ST_HOLD: begin
        if (!on_cmd) begin
          state_next = ST_OFF;
        end else if (!uv_active_reg) begin
          state_next = ST_RUN; // [RULE_14] [RULE_21]
        end
      end
      ST_RETRY: begin
        if (!on_cmd) begin
          state_next = ST_OFF; // [RULE_16]
        end else if (retry_cnt_reg >= retry_target) begin
          state_next = ST_RUN; // [RULE_16] [RULE_17]
        end
      end
      ST_LATCH: begin
        if (!on_cmd) begin
          state_next = ST_OFF; // [RULE_15]
        end
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      power_stage_en <= 1'b0;
    end else begin
      power_stage_en <= state_next == ST_RUN; // [RULE_13]
    end
  end

endmodule : ivm_input_voltage_limit_monitor

// ==== src/ivm_lin11_cmp.sv ====
// Magnitude compare of two linear-11 words
`timescale 1ns/1ps
module ivm_lin11_cmp
  import ivm_pkg::*;
(
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  output logic             a_gt_b,
  output logic             a_lt_b
);

  // Y * 2^N scaled by 2^16 so every exponent becomes a plain left shift
  function automatic logic signed [47:0] to_fixed(input logic [15:0] w);
    logic signed [47:0] y;
    logic signed [5:0]  n;
    y = 48'(signed'(w[LIN_EXP_LSB-1:0]));
    n = 6'(signed'(w[15:LIN_EXP_LSB]));
    return y <<< 6'(n + 6'sd16);
  endfunction : to_fixed

  always_comb begin
    a_gt_b = to_fixed(a) > to_fixed(b);
    a_lt_b = to_fixed(a) < to_fixed(b);
  end

endmodule : ivm_lin11_cmp

// ==== src/ivm_link_port.sv ====
// Link-clock side of the management serial port
`timescale 1ns/1ps
module ivm_link_port
  import ivm_pkg::*;
(
  input  wire logic        link_clk,
  input  wire logic        sys_rst,
  input  wire logic        link_frame_n,
  input  wire logic        link_din,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_ack_tgl,
  output logic             link_dout,
  output logic             link_dout_oe,
  output ivm_req_t         req_hold,
  output logic             req_tgl
);

  logic [4:0]  bit_cnt_reg;
  logic [23:0] shift_reg;
  logic [15:0] out_reg;
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic        ack_seen_reg;
  logic        frame_rst;

  // The clock may stop between frames, so the frame pin itself ends a frame
  assign frame_rst = sys_rst | link_frame_n;

  always_ff @(posedge link_clk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg  <= 5'h00;
      shift_reg    <= 24'h000000;
      out_reg      <= 16'h0000;
      link_dout    <= 1'b0;
      link_dout_oe <= 1'b0;
    end else if (bit_cnt_reg != LINK_FRAME_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_reg   <= {shift_reg[22:0], link_din};
      if (bit_cnt_reg == LINK_HDR_BITS - 5'h01) begin
        // Fresh read data only; otherwise the data phase reads zero
        out_reg      <= (ack_s2_reg != ack_seen_reg) ? {rd_data[14:0], 1'b0} : 16'h0000;
        link_dout    <= (ack_s2_reg != ack_seen_reg) ? rd_data[15] : 1'b0;
        link_dout_oe <= 1'b1;
      end else if (bit_cnt_reg == LINK_FRAME_BITS - 5'h01) begin
        link_dout_oe <= 1'b0;
        link_dout    <= 1'b0;
      end else begin
        out_reg   <= {out_reg[14:0], 1'b0};
        link_dout <= out_reg[15];
      end
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_s1_reg   <= 1'b0;
      ack_s2_reg   <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      ack_s1_reg <= rd_ack_tgl;
      ack_s2_reg <= ack_s1_reg;
      if (!link_frame_n && bit_cnt_reg == LINK_HDR_BITS - 5'h01) begin
        ack_seen_reg <= ack_s2_reg;
      end
    end
  end

  // Hold stays put until the next request, long after the system side took it
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_hold <= '0;
      req_tgl  <= 1'b0;
    end else if (!link_frame_n) begin
      if (bit_cnt_reg == LINK_HDR_BITS - 5'h01 && shift_reg[7]) begin
        req_hold <= {1'b1, shift_reg[6:0], link_din, 16'h0000};
        req_tgl  <= ~req_tgl;
      end else if (bit_cnt_reg == LINK_FRAME_BITS - 5'h01 && !shift_reg[23]) begin
        req_hold <= {shift_reg, link_din};
        req_tgl  <= ~req_tgl;
      end
    end
  end

endmodule : ivm_link_port

// ==== src/ivm_pkg.sv ====
// Shared constants and types of the input voltage limit monitor
package ivm_pkg;

  // ****************************************
  // Command codes on the management link
  // ****************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_WARN      = 8'h57;
  localparam logic [7:0] CMD_UV_WARN      = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT     = 8'h59;
  localparam logic [7:0] CMD_UV_RESP      = 8'h5a;
  localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] OV_WARN_RST  = 16'hd3a0;
  localparam logic [15:0] UV_WARN_RST  = 16'hcba6;
  localparam logic [15:0] UV_FAULT_RST = 16'hcb73;
  localparam logic [7:0]  UV_RESP_RST  = 8'hbf;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LIN_EXP_LSB   = 11;
  localparam int RESP_MODE_LSB = 6;
  localparam int RETRY_LSB     = 3;
  localparam int DELAY_LSB     = 0;
  localparam logic [1:0] MODE_RETRY = 2'h2;
  localparam logic [1:0] MODE_HOLD  = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_EVER = 3'h7;

  localparam int SIN_OV_WARN  = 6;
  localparam int SIN_UV_WARN  = 5;
  localparam int SIN_UV_FAULT = 4;
  localparam int SW_INPUT     = 13;
  localparam int SW_NONE      = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned RETRY_UNIT_MS = 35;
  localparam int unsigned RETRY_UNIT_CYC_DEF = CLK_HZ / 1000 * RETRY_UNIT_MS;

  localparam logic [4:0] LINK_HDR_BITS   = 5'h09;
  localparam logic [4:0] LINK_FRAME_BITS = 5'h19;

  typedef struct packed {
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] data;
  } ivm_req_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_RUN   = 3'b001,
    ST_HOLD  = 3'b010,
    ST_RETRY = 3'b011,
    ST_LATCH = 3'b100
  } ivm_state_t;

endpackage : ivm_pkg
